// ### logic/adc_power_filter_ctrl.sv
`timescale 1ns/1ns
// Function
// - mode register bits 4:3 pick normal, low power or low power plus.
// - core power control register is separate; ADC mode writes never touch it.
// - comparator mode raises interrupt when result magnitude exceeds threshold.
// - threshold event counter raises interrupt on reaching count limit.
// - 32-bit accumulator adds or subtracts results, readable, set by config 6:5.
// - normal mode runs modulators at 512 kHz, all channels, 4 Hz to 8 kHz.
// - filter configuration resets to 0x0007, 1 kHz, extras off.
// - single mode converts once at normal power then powers down.
// - low power runs current channel only, 131 kHz clock, gain 128.
// - counters, comparator, accumulator work in both low power modes.
// - low power plus is like low power with gain 512.
// - in low power modes mode bit 5 picks precision or low power reference.
// - filter bits 6:0 decimation, 13:8 averaging, same for all channels.
// - slowest update limited to 4 Hz normal, 1 Hz low power.
// - second notch bit adds notch at 1.333 times first notch.
// - filter 0x0000 in normal mode gives 8 kHz.
// - bit 14 adds two-sample running average, one extra settling period.
// - bit 15 enables offset swapping; 0x1F with 0x16 gives 10 Hz.
// - offset swapping, 0x1D with 0x3F gives 4 Hz minimum.
// - low power filter 0xBD1F gives 1 Hz.
// - event counter rises when magnitude at or above threshold, else falls/clears.
// - result counter wraps to zero at limit, clears on reconfiguration.
module adc_power_filter_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]                 regWrData,
  input  wire logic                        regWrStb,
  input  wire logic                        regRdStb,
  output logic      [31:0]                 regRdData,
  input  wire logic [15:0]                 rawSample,
  output logic      [15:0]                 resultData,
  output logic                             resultValid,
  output logic                             adcIrq,
  output logic                             modClkEn,
  output logic      [9:0]                  pgaGain,
  output adc_ctrl_pkg::chan_ctl_type       chanCtl,
  output logic      [7:0]                  corePowerCtrl
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    mode_type       mode;
    config_type     cfg;
    filter_type     filt;
    logic [15:0]    curCtrl;
    logic [15:0]    thresh;
    logic [7:0]     tcl;
    logic [7:0]     thv;
    logic [31:0]    acc;
    logic [15:0]    rcl;
    logic [15:0]    rcv;
    status_type     status;
    logic [7:0]     corePwr;
    conv_state_type conv;
    logic           havePrev;
    logic [15:0]    prevSample;
    logic [15:0]    result;
    logic           resultValid;
    logic           irq;
    logic [31:0]    rdData;
    logic [9:0]     gain;
    logic           modTick;
    chan_ctl_type   chan;
    logic           restart;
  } ctrl_state_type;

  ctrl_state_type   st;
  ctrl_state_type   nx;
  logic             modTickRaw;
  logic             convTick;
  logic             lowPwr;
  logic             lowPlus;
  logic             reconfig;
  logic             modeWrite;
  logic             produce;
  logic [16:0]      avgSum;
  logic [15:0]      outVal;
  logic [15:0]      mag;
  logic [14:0]      sfAf;
  logic [6:0]       afTerm;
  logic [7:0]       sfTerm;
  logic [PER_W-1:0] convPer;
  logic [PER_W-1:0] rawPer;
  logic [3:0]       gainCode;

  // effective power mode; single conversions always run at normal power
  assign lowPwr = (st.mode.op != OP_SINGLE) && (st.mode.pwr == PWR_LOW ||
                  st.mode.pwr == PWR_LOW_PLUS);
  assign lowPlus = lowPwr && (st.mode.pwr == PWR_LOW_PLUS);
  assign modeWrite = regWrStb && (regAddr == ADDR_MODE);
  assign reconfig = regWrStb && (regAddr == ADDR_MODE || regAddr == ADDR_FILTER ||
                    regAddr == ADDR_CURCTRL);

  // conversion period in modulator ticks: 64 * (SF+1) * (AF+1 or AF+3)
  assign sfTerm = {1'b0, st.filt.decimationFactor} + 8'h01;
  assign afTerm = {1'b0, st.filt.averagingFactor} +
                  (st.filt.chop ? AF_CHOP_ADD : AF_PLAIN_ADD);
  assign sfAf = 15'(sfTerm) * 15'(afTerm);
  assign rawPer = PER_W'({sfAf, {DECIM_SHIFT{1'b0}}});
  // clamp to the slowest legal update rate
  assign convPer = lowPwr ? ((rawPer > MAX_PER_LP) ? MAX_PER_LP : rawPer)
                          : ((rawPer > MAX_PER_NORM) ? MAX_PER_NORM : rawPer);

  // modulator clock enable: 512 kHz normal, 131 kHz low power
  adc_tick_div #(
    .W (DIV_W)
  ) modDiv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (st.mode.op != OP_POWERDOWN),
    .restart (st.restart),
    .period  (lowPwr ? DIV_LP : DIV_NORM),
    .tick    (modTickRaw)
  );

  // conversion boundary counter in modulator ticks
  adc_tick_div #(
    .W (PER_W)
  ) convDiv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (modTickRaw && st.conv != CONV_STOPPED),
    .restart (st.restart),
    .period  (convPer),
    .tick    (convTick)
  );

  // sample path: optional two-sample running average
  assign avgSum = {st.prevSample[15], st.prevSample} + {rawSample[15], rawSample};
  assign outVal = st.filt.runAvg ? avgSum[16:1] : rawSample;
  assign mag = outVal[15] ? (~outVal) + 16'h0001 : outVal;

  // next-state: register writes, result handling, outputs
  always_comb
  begin
    nx = st;
    nx.resultValid = 1'b0;
    nx.restart = 1'b0;
    nx.rdData = '0;
    nx.modTick = modTickRaw;
    produce = 1'b0;
    gainCode = st.curCtrl[GAIN_CODE_W-1:0];
    if (regWrStb)
    begin
      case (regAddr)
        ADDR_MODE:    nx.mode = mode_type'(regWrData[7:0]);
        ADDR_CONFIG:  nx.cfg = config_type'(regWrData[15:0]);
        ADDR_FILTER:  nx.filt = filter_type'(regWrData[15:0]);
        ADDR_CURCTRL: nx.curCtrl = regWrData[15:0];
        ADDR_THRESH:  nx.thresh = regWrData[15:0];
        ADDR_TCL:     nx.tcl = regWrData[7:0];
        ADDR_RCL:     nx.rcl = regWrData[15:0];
        ADDR_STATUS:  nx.status = st.status & ~status_type'(regWrData[7:0]);
        ADDR_COREPWR: nx.corePwr = regWrData[7:0];
        default:      ;
      endcase
    end
    // reconfiguration discards partial work and clears the result count and accumulator; the event count is kept
    if (reconfig)
    begin
      nx.restart = 1'b1;
      nx.rcv = '0;
      nx.acc = '0;
      nx.havePrev = 1'b0;
    end
    // conversion boundary; identical in every power mode
    if (convTick && st.conv != CONV_STOPPED && !st.restart && !reconfig)
    begin
      nx.havePrev = 1'b1;
      nx.prevSample = rawSample;
      produce = !st.filt.runAvg || st.havePrev;
    end
    if (produce)
    begin
      nx.result = outVal;
      nx.resultValid = 1'b1;
      nx.status.ready = 1'b1;
      case (st.cfg.cmp)
        CMP_TRIP:
        begin
          if (mag > st.thresh)
            nx.status.cmpTrip = 1'b1;
        end
        CMP_COUNT_DEC, CMP_COUNT_CLR:
        begin
          if (mag >= st.thresh)
            nx.thv = (st.thv == THV_MAX) ? st.thv : st.thv + 8'h01;
          else if (st.cfg.cmp == CMP_COUNT_CLR || st.thv == 8'h00)
            nx.thv = 8'h00;
          else
            nx.thv = st.thv - 8'h01;
          if (nx.thv == st.tcl)
            nx.status.countReached = 1'b1;
        end
        default: ;
      endcase
      case (st.cfg.acc)
        ACC_ADD, ACC_ADD_ALT: nx.acc = st.acc + {{16{outVal[15]}}, outVal};
        ACC_SUB:              nx.acc = st.acc - {{16{outVal[15]}}, outVal};
        default:              ;
      endcase
      if (st.cfg.rcEn)
      begin
        if (st.rcv + 16'h0001 >= st.rcl)
        begin
          nx.rcv = '0;
          nx.status.rcReached = 1'b1;
        end
        else
          nx.rcv = st.rcv + 16'h0001;
      end
      if (st.conv == CONV_SINGLE && !modeWrite)
        nx.mode.op = OP_POWERDOWN;
    end
    // a disabled accumulator stays clear, even past a same-cycle result
    if (nx.cfg.acc == ACC_OFF)
      nx.acc = '0;
    // conversion state follows the operating mode field
    case (nx.mode.op)
      OP_CONTINUOUS: nx.conv = CONV_CONT;
      OP_SINGLE:     nx.conv = CONV_SINGLE;
      default:       nx.conv = CONV_STOPPED;
    endcase
    // gain and channel controls from the effective power mode
    if (gainCode > GAIN_CODE_MAX)
      gainCode = GAIN_CODE_MAX;
    nx.gain = lowPlus ? GAIN_LP_PLUS : (lowPwr ? GAIN_LP : (GAIN_ONE << gainCode));
    nx.chan.curOn = st.mode.op != OP_POWERDOWN && st.curCtrl[CUR_EN_BIT];
    nx.chan.voltOn = st.mode.op != OP_POWERDOWN && !lowPwr && st.cfg.voltEn;
    nx.chan.tempOn = st.mode.op != OP_POWERDOWN && !lowPwr && st.cfg.tempEn;
    nx.chan.lowPowerRef = lowPwr && !st.mode.precisionRef;
    nx.chan.secondNotch = st.filt.secondNotch;
    nx.chan.chop = st.filt.chop;
    // result counter gates the ready interrupt when enabled
    nx.irq = nx.status.cmpTrip || nx.status.countReached ||
             (nx.cfg.rcEn ? nx.status.rcReached : nx.status.ready);
    if (regRdStb)
    begin
      case (regAddr)
        ADDR_MODE:    nx.rdData = 32'(st.mode);
        ADDR_CONFIG:  nx.rdData = 32'(st.cfg);
        ADDR_FILTER:  nx.rdData = 32'(st.filt);
        ADDR_CURCTRL: nx.rdData = 32'(st.curCtrl);
        ADDR_THRESH:  nx.rdData = 32'(st.thresh);
        ADDR_TCL:     nx.rdData = 32'(st.tcl);
        ADDR_THV:     nx.rdData = 32'(st.thv);
        ADDR_ACC:     nx.rdData = st.acc;
        ADDR_RCL:     nx.rdData = 32'(st.rcl);
        ADDR_RCV:     nx.rdData = 32'(st.rcv);
        ADDR_STATUS:  nx.rdData = 32'(st.status);
        ADDR_COREPWR: nx.rdData = 32'(st.corePwr);
        default:      nx.rdData = '0;
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.filt <= filter_type'(FILTER_RESET);
      st.rcl <= RCL_RESET;
      st.tcl <= TCL_RESET;
      st.gain <= GAIN_ONE;
      st.conv <= CONV_STOPPED;
    end
    else
      st <= nx;
  end

  // outputs straight from the state register
  assign regRdData = st.rdData;
  assign resultData = st.result;
  assign resultValid = st.resultValid;
  assign adcIrq = st.irq;
  assign modClkEn = st.modTick;
  assign pgaGain = st.gain;
  assign chanCtl = st.chan;
  assign corePowerCtrl = st.corePwr;

  // checks
  AST_PWR_FIELD: assert property (@(posedge clk) disable iff (sys_rst)
    modeWrite |=> st.mode.pwr == pwr_mode_type'($past(regWrData[4:3])))
    else $error("power mode field not taken from write");
  AST_CORE_INDEP: assert property (@(posedge clk) disable iff (sys_rst)
    !(regWrStb && regAddr == ADDR_COREPWR) |=> $stable(corePowerCtrl))
    else $error("core power control changed without its own write");
  AST_CMP_TRIP: assert property (@(posedge clk) disable iff (sys_rst)
    produce && st.cfg.cmp == CMP_TRIP && mag > st.thresh |=> st.status.cmpTrip ##1 adcIrq)
    else $error("comparator trip did not raise interrupt");
  AST_COUNT_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
    produce && st.cfg.cmp[1] && nx.thv == st.tcl |=> st.status.countReached && adcIrq)
    else $error("threshold count limit missed");
  AST_THV_UP: assert property (@(posedge clk) disable iff (sys_rst)
    produce && st.cfg.cmp[1] && mag >= st.thresh && st.thv != THV_MAX
    |=> st.thv == $past(st.thv) + 8'h01)
    else $error("event counter did not rise");
  AST_ACC_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    st.cfg.acc == ACC_OFF |-> st.acc == '0)
    else $error("accumulator not cleared while disabled");
  AST_GAIN_LP: assert property (@(posedge clk) disable iff (sys_rst)
    lowPwr && !lowPlus ##1 lowPwr && !lowPlus |-> pgaGain == GAIN_LP && !chanCtl.voltOn)
    else $error("low power gain or channel wrong");
  AST_GAIN_LPP: assert property (@(posedge clk) disable iff (sys_rst)
    lowPlus |=> pgaGain == GAIN_LP_PLUS)
    else $error("low power plus gain wrong");
  AST_FILT_RESET: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> st.filt == filter_type'(FILTER_RESET))
    else $error("filter reset value wrong");
  AST_SINGLE_DONE: assert property (@(posedge clk) disable iff (sys_rst)
    produce && st.conv == CONV_SINGLE && !modeWrite
    |=> st.mode.op == OP_POWERDOWN && st.conv == CONV_STOPPED)
    else $error("single conversion did not power down");
  AST_RECONFIG: assert property (@(posedge clk) disable iff (sys_rst)
    reconfig |=> st.rcv == '0 && st.acc == '0 && st.restart ##1 !resultValid)
    else $error("reconfiguration did not restart");
  AST_RATE_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
    convPer <= (lowPwr ? MAX_PER_LP : MAX_PER_NORM))
    else $error("conversion period beyond slowest rate");
endmodule : adc_power_filter_ctrl

// ### shared/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // clock and modulator rates
  localparam int CLK_HZ      = 50_000_000;
  localparam int NORM_MOD_HZ = 512_000;
  localparam int LP_MOD_HZ   = 131_000;
  localparam int MIN_HZ_NORM = 4;
  localparam int MIN_HZ_LP   = 1;
  localparam int DIV_W       = 9;
  localparam int PER_W       = 21;
  localparam int DECIM_SHIFT = 6;
  localparam logic [DIV_W-1:0] DIV_NORM = DIV_W'(CLK_HZ / NORM_MOD_HZ);
  localparam logic [DIV_W-1:0] DIV_LP   = DIV_W'(CLK_HZ / LP_MOD_HZ);
  localparam logic [PER_W-1:0] MAX_PER_NORM = PER_W'(NORM_MOD_HZ / MIN_HZ_NORM);
  localparam logic [PER_W-1:0] MAX_PER_LP   = PER_W'(LP_MOD_HZ / MIN_HZ_LP);
  localparam logic [6:0] AF_CHOP_ADD  = 7'h03;
  localparam logic [6:0] AF_PLAIN_ADD = 7'h01;
  // gain settings
  localparam logic [9:0] GAIN_ONE     = 10'h001;
  localparam logic [9:0] GAIN_LP      = 10'h080;
  localparam logic [9:0] GAIN_LP_PLUS = 10'h200;
  localparam int         GAIN_CODE_W  = 4;
  localparam logic [3:0] GAIN_CODE_MAX = 4'h9;
  localparam int         CUR_EN_BIT   = 15;
  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MODE    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_FILTER  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CURCTRL = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_THRESH  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_TCL     = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_THV     = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_ACC     = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_RCL     = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_RCV     = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_COREPWR = 4'hB;
  // reset values
  localparam logic [15:0] FILTER_RESET = 16'h0007;
  localparam logic [15:0] RCL_RESET    = 16'h0001;
  localparam logic [7:0]  TCL_RESET    = 8'h01;
  localparam logic [7:0]  THV_MAX      = 8'hFF;

  typedef enum logic [2:0] {
    OP_POWERDOWN = 3'h0, OP_CONTINUOUS = 3'h1, OP_SINGLE = 3'h2, OP_IDLE = 3'h3,
    OP_SELF_OFFSET = 3'h4, OP_SELF_GAIN = 3'h5, OP_SYS_OFFSET = 3'h6, OP_SYS_GAIN = 3'h7
  } op_mode_type;
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0, PWR_LOW = 2'h1, PWR_LOW_PLUS = 2'h2, PWR_RSVD = 2'h3
  } pwr_mode_type;
  typedef enum logic [1:0] {
    CMP_OFF = 2'h0, CMP_TRIP = 2'h1, CMP_COUNT_DEC = 2'h2, CMP_COUNT_CLR = 2'h3
  } cmp_mode_type;
  typedef enum logic [1:0] {
    ACC_OFF = 2'h0, ACC_ADD = 2'h1, ACC_SUB = 2'h2, ACC_ADD_ALT = 2'h3
  } acc_mode_type;
  typedef enum logic [2:0] {
    CONV_STOPPED = 3'b001, CONV_CONT = 3'b010, CONV_SINGLE = 3'b100
  } conv_state_type;

  typedef struct packed {
    logic [1:0]   spare;
    logic         precisionRef;
    pwr_mode_type pwr;
    op_mode_type  op;
  } mode_type;
  typedef struct packed {
    logic [5:0]   spareHi;
    logic         tempEn;
    logic         voltEn;
    logic         spareMid;
    acc_mode_type acc;
    cmp_mode_type cmp;
    logic [1:0]   spareLo;
    logic         rcEn;
  } config_type;
  typedef struct packed {
    logic       chop;
    logic       runAvg;
    logic [5:0] averagingFactor;
    logic       secondNotch;
    logic [6:0] decimationFactor;
  } filter_type;
  typedef struct packed {
    logic [3:0] spare;
    logic       rcReached;
    logic       countReached;
    logic       cmpTrip;
    logic       ready;
  } status_type;
  typedef struct packed {
    logic curOn;
    logic voltOn;
    logic tempOn;
    logic lowPowerRef;
    logic secondNotch;
    logic chop;
  } chan_ctl_type;
endpackage : adc_ctrl_pkg

// ### logic/adc_tick_div.sv
`timescale 1ns/1ns
module adc_tick_div #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         enable,
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  output logic              tick
);
  localparam logic [W-1:0] ONE = W'(1);

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } div_state_type;

  div_state_type st;
  div_state_type nx;

  // count enables, pulse at period end; a shrunk period ends at once
  always_comb
  begin
    nx = st;
    nx.tick = 1'b0;
    if (restart)
      nx.count = '0;
    else if (enable)
    begin
      if (st.count >= period - ONE)
      begin
        nx.count = '0;
        nx.tick = 1'b1;
      end
      else
        nx.count = st.count + ONE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= nx;
  end

  assign tick = st.tick;
endmodule : adc_tick_div

// ### verif/test_adc_power_filter_ctrl.sv
`timescale 1ns/1ns
module test_adc_power_filter_ctrl;
  import adc_ctrl_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData;
  logic              regWrStb;
  logic              regRdStb;
  logic [31:0]       regRdData;
  logic [15:0]       rawSample;
  logic [15:0]       resultData;
  logic              resultValid;
  logic              adcIrq;
  logic              modClkEn;
  logic [9:0]        pgaGain;
  chan_ctl_type      chanCtl;
  logic [7:0]        corePowerCtrl;
  int                errors;
  int                checks;
  logic [31:0]       rdQ[$];
  logic [15:0]       resQ[$];
  logic              rdPend;
  logic [31:0]       rng;
  logic [31:0]       rv;
  logic [31:0]       sx;
  logic [7:0]        modeTab [4] = '{8'h03, 8'h0B, 8'h13, 8'h2B};
  logic [9:0]        gainTab [4] = '{10'h080, 10'h080, 10'h200, 10'h080};
  logic [5:0]        chanTab [4] = '{6'h38, 6'h24, 6'h24, 6'h20};

  adc_power_filter_ctrl dut_u (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWrStb      (regWrStb),
    .regRdStb      (regRdStb),
    .regRdData     (regRdData),
    .rawSample     (rawSample),
    .resultData    (resultData),
    .resultValid   (resultValid),
    .adcIrq        (adcIrq),
    .modClkEn      (modClkEn),
    .pgaGain       (pgaGain),
    .chanCtl       (chanCtl),
    .corePowerCtrl (corePowerCtrl)
  );

  // free-running 50 MHz clock
  always #10 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] xorShift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorShift

  task automatic finish_test;
    $display("counts: checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrStb  <= 1'b0;
  endtask : wr

  // one-cycle read strobe, expected data noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    @(posedge clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge clk);
    regRdStb <= 1'b0;
  endtask : rd

  // start conversions and wait, bounded, for n results
  task automatic run(input logic [7:0] mode, input int n);
    int k;
    wr(ADDR_MODE, {24'h0, mode});
    // note expected results only once the new sample stands
    for (k = 0; k < n; k++)
    begin
      resQ.push_back(rawSample);
    end
    k = 0;
    while (resQ.size() != 0 && k < 40000)
    begin
      @(posedge clk);
      k++;
    end
    check(32'(resQ.size()), 32'h0);
  endtask : run

  // count modulator enable pulses over a span of clock cycles
  task automatic count_ticks(input int span, input logic [31:0] exp);
    int n;
    n = 0;
    repeat (span)
    begin
      @(posedge clk);
      if (modClkEn)
        n++;
    end
    check(32'(n), exp);
  endtask : count_ticks

  // monitor: read data one cycle after strobe, results when valid
  always @(posedge clk)
  begin
    if (rdPend)
      check(regRdData, rdQ.pop_front());
    if (resultValid && resQ.size() != 0)
      check({16'h0, resultData}, {16'h0, resQ.pop_front()});
    else if (resultValid)
      check({16'h0, resultData}, 32'hFFFF_FFFF);
    rdPend <= regRdStb;
  end

  // watchdog: the tests need about 85000 cycles
  initial
  begin
    repeat (95000) @(posedge clk);
    errors = errors + 1;
    $display("BAD t=%0t watchdog seen=%h exp=%h", $time, 32'h1, 32'h0);
    finish_test();
  end

  initial
  begin
    errors    = 0;
    checks    = 0;
    clk       = 1'b0;
    sys_rst   = 1'b1;
    regAddr   = '0;
    regWrData = '0;
    regWrStb  = 1'b0;
    regRdStb  = 1'b0;
    rawSample = '0;
    rdPend    = 1'b0;
    rng       = 32'h2FEF;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped index
    rd(ADDR_FILTER, 32'h0000_0007);
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_TCL, 32'h1);
    rd(ADDR_RCL, 32'h1);
    rd(4'hC, 32'h0);
    $display("test reset done");
    // core power untouched by the startup mode writes
    rng = xorShift(rng);
    wr(ADDR_COREPWR, {24'h0, rng[7:0]});
    // startup sequence; current channel on at gain code 7, voltage and temperature enabled
    wr(ADDR_CURCTRL, 32'h8007);
    wr(ADDR_MODE, 32'h09);
    wr(ADDR_MODE, 32'h03);
    wr(ADDR_CONFIG, 32'h0300);
    check({24'h0, corePowerCtrl}, {24'h0, rng[7:0]});
    rd(ADDR_COREPWR, {24'h0, rng[7:0]});
    $display("test core power done");
    // power modes: gain, channel enables, reference
    for (int j = 0; j < 4; j++)
    begin
      wr(ADDR_MODE, {24'h0, modeTab[j]});
      repeat (2) @(posedge clk);
      check({22'h0, pgaGain}, {22'h0, gainTab[j]});
      check({26'h0, chanCtl}, {26'h0, chanTab[j]});
      rd(ADDR_MODE, {24'h0, modeTab[j]});
    end
    count_ticks(4 * DIV_LP, 32'h4);
    $display("test power modes done");
    // filter fields, read-only write ignored
    wr(ADDR_MODE, 32'h03);
    rng = xorShift(rng);
    rv = {16'h0, rng[15:0]};
    wr(ADDR_FILTER, rv);
    rd(ADDR_FILTER, rv);
    repeat (2) @(posedge clk);
    check({26'h0, chanCtl}, {26'h0, 3'h7, 1'b0, rv[7], rv[15]});
    count_ticks(10 * DIV_NORM, 32'hA);
    wr(ADDR_FILTER, 32'h0000);
    wr(ADDR_ACC, 32'hFFFF_FFFF);
    rd(ADDR_ACC, 32'h0);
    $display("test filter done");
    // comparator: below then above threshold
    wr(ADDR_THRESH, 32'h0100);
    wr(ADDR_RCL, 32'h0100);
    wr(ADDR_CONFIG, 32'h0009);
    rawSample <= 16'h0080;
    run(8'h01, 1);
    wr(ADDR_MODE, 32'h03);
    wr(ADDR_STATUS, 32'hF);
    repeat (2) @(posedge clk);
    check({31'h0, adcIrq}, 32'h0);
    rawSample <= 16'hFE00;
    run(8'h01, 1);
    wr(ADDR_MODE, 32'h03);
    repeat (2) @(posedge clk);
    check({31'h0, adcIrq}, 32'h1);
    $display("test comparator done");
    // threshold event counter reaching its limit
    wr(ADDR_STATUS, 32'hF);
    wr(ADDR_TCL, 32'h2);
    wr(ADDR_CONFIG, 32'h0011);
    rawSample <= 16'h0200;
    run(8'h01, 2);
    rd(ADDR_THV, 32'h2);
    wr(ADDR_MODE, 32'h03);
    repeat (2) @(posedge clk);
    check({31'h0, adcIrq}, 32'h1);
    $display("test event counter done");
    // accumulator add, subtract, and add in low power
    for (int j = 0; j < 3; j++)
    begin
      rng = xorShift(rng);
      rawSample <= rng[15:0];
      sx = {{16{rng[15]}}, rng[15:0]};
      wr(ADDR_CONFIG, (j == 1) ? 32'h0041 : 32'h0021);
      wr(ADDR_FILTER, (j == 0) ? 32'h4000 : 32'h0000);
      run((j == 2) ? 8'h09 : 8'h01, 1);
      rd(ADDR_ACC, (j == 1) ? -sx : sx);
      rd(ADDR_RCV, 32'h1);
      wr(ADDR_MODE, 32'h03);
      rd(ADDR_RCV, 32'h0);
    end
    $display("test accumulator done");
    // single conversion then power-down, no further results
    rng = xorShift(rng);
    rawSample <= rng[15:0];
    run(8'h02, 1);
    repeat (3) @(posedge clk);
    rd(ADDR_MODE, 32'h0);
    repeat (7000) @(posedge clk);
    $display("test single done");
    finish_test();
  end
endmodule : test_adc_power_filter_ctrl
